// ### sfd_pkg.sv
// sfd_pkg: constants and types of the serial flash command decoder
`default_nettype none
package sfd_pkg;
  // ==========================================================
  // framing
  localparam int SFD_BYTE_W = 8;
  localparam int SFD_ADDR_W = 22;
  localparam int SFD_ADDR_BYTES = 3;
  localparam int SFD_CNT_W = 9;
  localparam logic [2:0] SFD_BIT_RST = 3'h0;
  localparam logic [1:0] SFD_ABYTE_LAST = 2'h2;
  localparam logic [8:0] SFD_CNT_MAX = 9'h1ff;
  localparam logic [7:0] SFD_IDLE_OUT = 8'hff;
  // ==========================================================
  // opcodes
  localparam logic [7:0] OPC_READ_FAST = 8'h0b;
  localparam logic [7:0] OPC_READ_SLOW = 8'h03;
  localparam logic [7:0] OPC_ERASE_4K = 8'h20;
  localparam logic [7:0] OPC_ERASE_32K = 8'h52;
  localparam logic [7:0] OPC_ERASE_64K = 8'hd8;
  localparam logic [7:0] OPC_CHIP_A = 8'h60;
  localparam logic [7:0] OPC_CHIP_B = 8'hc7;
  localparam logic [7:0] OPC_PROGRAM = 8'h02;
  localparam logic [7:0] OPC_WR_EN = 8'h06;
  localparam logic [7:0] OPC_WR_DIS = 8'h04;
  localparam logic [7:0] OPC_PROTECT = 8'h36;
  localparam logic [7:0] OPC_UNPROTECT = 8'h39;
  localparam logic [7:0] OPC_READ_PROT = 8'h3c;
  localparam logic [7:0] OPC_READ_STAT = 8'h05;
  localparam logic [7:0] OPC_WRITE_STAT = 8'h01;
  localparam logic [7:0] OPC_READ_ID = 8'h9f;
  localparam logic [7:0] OPC_PDOWN = 8'hb9;
  localparam logic [7:0] OPC_RESUME = 8'hab;
  // ==========================================================
  // types
  typedef enum logic [4:0] {
    CMD_NONE = 5'h00, CMD_READ_FAST = 5'h01, CMD_READ_SLOW = 5'h02,
    CMD_PROGRAM = 5'h03, CMD_ERASE_4K = 5'h04, CMD_ERASE_32K = 5'h05,
    CMD_ERASE_64K = 5'h06, CMD_CHIP_ERASE = 5'h07, CMD_WR_EN = 5'h08,
    CMD_WR_DIS = 5'h09, CMD_PROTECT = 5'h0a, CMD_UNPROTECT = 5'h0b,
    CMD_READ_PROT = 5'h0c, CMD_READ_STAT = 5'h0d, CMD_WRITE_STAT = 5'h0e,
    CMD_READ_ID = 5'h0f, CMD_PDOWN = 5'h10, CMD_RESUME = 5'h11
  } sfd_cmd_t;
  typedef enum logic [1:0] {
    SRC_ARRAY = 2'b00, SRC_PROT = 2'b01, SRC_STATUS = 2'b10, SRC_ID = 2'b11
  } sfd_src_t;
  typedef struct packed {
    sfd_src_t src;
    logic [SFD_ADDR_W-1:0] addr;
  } sfd_fetch_t;
  typedef struct packed {
    sfd_cmd_t cmd;
    logic [SFD_ADDR_W-1:0] addr;
    logic [SFD_CNT_W-1:0] nbytes;
  } sfd_done_t;
endpackage : sfd_pkg
`default_nettype wire

// ### sfd_decoder.sv
// sfd_decoder: spi slave framing, opcode decode and read streaming
// How it works
// - all bytes shift most significant bit first
// - unknown opcode ignored until next select
// - release during opcode or address aborts, back to idle
// - three address bytes, top two bits dropped
// - fast read has dummy byte, slow none
// - program 02h, address then data bytes
// - three block erase opcodes with address
// - 3ch reads protection bytes after address
// - 9fh streams identification bytes, no address
// - b9h and abh decoded without operands
// - read counter loaded then auto increments
// - after header each clock shifts data out
// - counter wraps to zero with no gap
// - select release ends read, output floats
// - sample on rising, drive on falling sck
// - 60h and c7h both erase whole chip
`timescale 1ns/10ps
`default_nettype none
module sfd_decoder #(
  parameter int BUF_DEPTH = 2
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_n_o,
  output logic fetch_valid_o,
  input wire logic fetch_ready_i,
  output sfd_pkg::sfd_fetch_t fetch_o,
  input wire logic fdata_valid_i,
  output logic fdata_ready_o,
  input wire logic [7:0] fdata_i,
  output logic wbyte_valid_o,
  output logic [7:0] wbyte_o,
  output logic done_valid_o,
  output sfd_pkg::sfd_done_t done_o,
  output logic abort_o,
  output logic underrun_o
);
  import sfd_pkg::*;

  localparam int PW = $clog2(BUF_DEPTH);
  localparam int CW = $clog2(BUF_DEPTH + 1);
  localparam logic [CW:0] DEPTH_C = (CW + 1)'(BUF_DEPTH);

  initial begin
    if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin
      $error("BUF_DEPTH must be a power of two, at least 2");
    end
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_OPC = 3'b001, ST_ADDR = 3'b010, ST_DUMMY = 3'b011,
    ST_OUT = 3'b100, ST_IN = 3'b101, ST_HOLD = 3'b110, ST_SKIP = 3'b111
  } sfd_state_t;

  // opcode decode: command plus needs of address, dummy, direction
  typedef struct packed {
    sfd_cmd_t cmd;
    logic adr;
    logic dum;
    logic out;
    logic inp;
  } sfd_fmt_t;

  function automatic sfd_fmt_t decode(input logic [7:0] op);
    sfd_fmt_t f;
    f = '{CMD_NONE, 1'b0, 1'b0, 1'b0, 1'b0};
    case (op)
      // fast read takes a dummy byte, slow read none
      OPC_READ_FAST: f = '{CMD_READ_FAST, 1'b1, 1'b1, 1'b1, 1'b0};
      OPC_READ_SLOW: f = '{CMD_READ_SLOW, 1'b1, 1'b0, 1'b1, 1'b0};
      OPC_PROGRAM: f = '{CMD_PROGRAM, 1'b1, 1'b0, 1'b0, 1'b1};
      OPC_ERASE_4K: f = '{CMD_ERASE_4K, 1'b1, 1'b0, 1'b0, 1'b0};
      OPC_ERASE_32K: f = '{CMD_ERASE_32K, 1'b1, 1'b0, 1'b0, 1'b0};
      OPC_ERASE_64K: f = '{CMD_ERASE_64K, 1'b1, 1'b0, 1'b0, 1'b0};
      OPC_CHIP_A, OPC_CHIP_B: f = '{CMD_CHIP_ERASE, 1'b0, 1'b0, 1'b0, 1'b0};
      OPC_WR_EN: f = '{CMD_WR_EN, 1'b0, 1'b0, 1'b0, 1'b0};
      OPC_WR_DIS: f = '{CMD_WR_DIS, 1'b0, 1'b0, 1'b0, 1'b0};
      OPC_READ_STAT: f = '{CMD_READ_STAT, 1'b0, 1'b0, 1'b1, 1'b0};
      OPC_WRITE_STAT: f = '{CMD_WRITE_STAT, 1'b0, 1'b0, 1'b0, 1'b1};
      OPC_PROTECT: f = '{CMD_PROTECT, 1'b1, 1'b0, 1'b0, 1'b0};
      OPC_UNPROTECT: f = '{CMD_UNPROTECT, 1'b1, 1'b0, 1'b0, 1'b0};
      OPC_READ_PROT: f = '{CMD_READ_PROT, 1'b1, 1'b0, 1'b1, 1'b0};
      OPC_READ_ID: f = '{CMD_READ_ID, 1'b0, 1'b0, 1'b1, 1'b0};
      OPC_PDOWN: f = '{CMD_PDOWN, 1'b0, 1'b0, 1'b0, 1'b0};
      OPC_RESUME: f = '{CMD_RESUME, 1'b0, 1'b0, 1'b0, 1'b0};
      default: f = '{CMD_NONE, 1'b0, 1'b0, 1'b0, 1'b0};
    endcase
    return f;
  endfunction : decode

  // ==========================================================
  // pin synchronisers and edge detection
  logic cs_s1_r, cs_s2_r, cs_d_r;
  logic sck_s1_r, sck_s2_r, sck_d_r;
  logic si_s1_r, si_s2_r;
  logic sck_rise, sck_fall, cs_fall, cs_rise, frame_end;

  // pins come from the host's domain; first stage feeds only the second
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_d_r <= 1'b1;
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_d_r <= 1'b0;
      si_s1_r <= 1'b0;
      si_s2_r <= 1'b0;
    end else begin
      cs_s1_r <= cs_n_i;
      cs_s2_r <= cs_s1_r;
      cs_d_r <= cs_s2_r;
      sck_s1_r <= sck_i;
      sck_s2_r <= sck_s1_r;
      sck_d_r <= sck_s2_r;
      si_s1_r <= si_i;
      si_s2_r <= si_s1_r;
    end
  end

  // edges qualified by an active select; si shares sck's delay
  assign sck_rise = sck_s2_r && !sck_d_r && !cs_s2_r;
  assign sck_fall = !sck_s2_r && sck_d_r && !cs_s2_r;
  assign cs_fall = !cs_s2_r && cs_d_r;
  assign cs_rise = cs_s2_r && !cs_d_r;

  // ==========================================================
  // receive shifter and frame state
  sfd_state_t state_r;
  sfd_fmt_t fmt_r, fmt_nxt;
  logic [2:0] bit_r;
  logic [7:0] rx_r, rx_nxt;
  logic [1:0] abyte_r;
  logic [23:0] addr_r, addr_nxt;
  logic [SFD_CNT_W-1:0] nbytes_r;
  logic byte_done;

  // msb arrives first, so shift left
  assign rx_nxt = {rx_r[6:0], si_s2_r};
  assign byte_done = sck_rise && (bit_r == 3'h7);
  assign addr_nxt = {addr_r[15:0], rx_nxt};
  assign fmt_nxt = decode(rx_nxt);
  assign frame_end = cs_rise;

  // bit counter and shifter of the incoming stream
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || cs_fall) begin
      bit_r <= SFD_BIT_RST;
      rx_r <= '0;
    end else if (sck_rise) begin
      bit_r <= bit_r + 3'h1;
      rx_r <= rx_nxt;
    end
  end

  // header walk: opcode, address, dummy, then payload direction
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      state_r <= ST_IDLE;
      fmt_r <= '{CMD_NONE, 1'b0, 1'b0, 1'b0, 1'b0};
      abyte_r <= 2'h0;
      addr_r <= '0;
    end else if (cs_rise) begin
      // release at any bit ends the frame
      state_r <= ST_IDLE;
    end else if (cs_fall) begin
      // select opens a frame with the opcode byte
      state_r <= ST_OPC;
      abyte_r <= 2'h0;
    end else if (byte_done) begin
      case (state_r)
        ST_OPC: begin
          fmt_r <= fmt_nxt;
          // unknown opcode: swallow input until reselect
          if (fmt_nxt.cmd == CMD_NONE) begin
            state_r <= ST_SKIP;
          end else if (fmt_nxt.adr) begin
            state_r <= ST_ADDR;
          end else if (fmt_nxt.out) begin
            state_r <= ST_OUT;
          end else if (fmt_nxt.inp) begin
            state_r <= ST_IN;
          end else begin
            state_r <= ST_HOLD;
          end
        end
        ST_ADDR: begin
          // three address bytes gathered msb first
          addr_r <= addr_nxt;
          abyte_r <= abyte_r + 2'h1;
          if (abyte_r == SFD_ABYTE_LAST) begin
            if (fmt_r.dum) begin
              state_r <= ST_DUMMY;
            end else if (fmt_r.out) begin
              state_r <= ST_OUT;
            end else if (fmt_r.inp) begin
              state_r <= ST_IN;
            end else begin
              state_r <= ST_HOLD;
            end
          end
        end
        ST_DUMMY: state_r <= ST_OUT;
        // status write takes exactly one byte, the rest is ignored
        ST_IN: begin
          if (fmt_r.cmd == CMD_WRITE_STAT) begin
            state_r <= ST_HOLD;
          end
        end
        default: state_r <= state_r;
      endcase
    end
  end

  // ==========================================================
  // data bytes in, and the closing report at select release
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      wbyte_valid_o <= 1'b0;
      wbyte_o <= '0;
      nbytes_r <= '0;
    end else begin
      wbyte_valid_o <= 1'b0;
      if (cs_fall) begin
        nbytes_r <= '0;
      end else if (byte_done && state_r == ST_IN && !cs_rise) begin
        // each complete data byte passed on
        wbyte_valid_o <= 1'b1;
        wbyte_o <= rx_nxt;
        if (nbytes_r != SFD_CNT_MAX) begin
          nbytes_r <= nbytes_r + 9'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      done_valid_o <= 1'b0;
      abort_o <= 1'b0;
      done_o <= '0;
    end else begin
      done_valid_o <= 1'b0;
      abort_o <= 1'b0;
      if (cs_rise) begin
        case (state_r)
          // opcode or address incomplete: nothing happens
          ST_OPC, ST_ADDR: abort_o <= 1'b1;
          ST_IN: begin
            // writes need at least one complete data byte
            abort_o <= (nbytes_r == '0);
            done_valid_o <= (nbytes_r != '0);
          end
          ST_DUMMY, ST_OUT, ST_HOLD: done_valid_o <= 1'b1;
          default: done_valid_o <= 1'b0;
        endcase
        done_o <= '{fmt_r.cmd, addr_r[SFD_ADDR_W-1:0], nbytes_r};
      end
    end
  end

  // ==========================================================
  // fetch side: address counter and credits toward the buffer
  logic fetch_en_r, drop_r;
  logic [SFD_ADDR_W-1:0] fcnt_r;
  sfd_src_t src_r;
  logic [CW-1:0] infl_r, cnt_r;
  logic req_fire, rsp_fire, push, pop, hdr_done;
  logic [7:0] buf_r [BUF_DEPTH];
  logic [PW-1:0] wptr_r, rptr_r;

  // header is complete once address (or opcode alone) is in
  assign hdr_done = byte_done && !cs_rise && (
    (state_r == ST_OPC && fmt_nxt.out && !fmt_nxt.adr) ||
    (state_r == ST_ADDR && abyte_r == SFD_ABYTE_LAST && fmt_r.out));

  // a request is issued only with room for its answer
  assign fetch_valid_o = fetch_en_r && !drop_r &&
    (({1'b0, cnt_r} + {1'b0, infl_r}) < DEPTH_C);
  assign fetch_o = '{src_r, fcnt_r};
  assign req_fire = fetch_valid_o && fetch_ready_i;
  // late answers of a closed frame are taken and thrown away
  assign fdata_ready_o = drop_r || ((CW + 1)'(cnt_r) < DEPTH_C);
  assign rsp_fire = fdata_valid_i && fdata_ready_o;
  assign push = rsp_fire && !drop_r && !frame_end;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      fetch_en_r <= 1'b0;
      src_r <= SRC_ARRAY;
      fcnt_r <= '0;
    end else if (frame_end) begin
      fetch_en_r <= 1'b0;
    end else if (hdr_done) begin
      // counter loaded from the start address
      fetch_en_r <= 1'b1;
      fcnt_r <= (state_r == ST_ADDR) ? addr_nxt[SFD_ADDR_W-1:0] : '0;
      case (state_r == ST_OPC ? fmt_nxt.cmd : fmt_r.cmd)
        CMD_READ_PROT: src_r <= SRC_PROT;
        CMD_READ_STAT: src_r <= SRC_STATUS;
        CMD_READ_ID: src_r <= SRC_ID;
        default: src_r <= SRC_ARRAY;
      endcase
    end else if (req_fire) begin
      // natural wrap from the top address to zero
      fcnt_r <= fcnt_r + 1'b1;
    end
  end

  // in-flight tracking; drop mode lasts until all answers are back
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      infl_r <= '0;
      drop_r <= 1'b0;
    end else begin
      infl_r <= infl_r + CW'(req_fire) - CW'(rsp_fire);
      if (frame_end && (infl_r + CW'(req_fire) - CW'(rsp_fire)) != '0) begin
        drop_r <= 1'b1;
      end else if (infl_r == CW'(rsp_fire) && !req_fire) begin
        drop_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // BUF_DEPTH-entry buffer (two by default): absorbs fetch latency so no word is lost
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || frame_end) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
      end
      cnt_r <= cnt_r + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (push) begin
      buf_r[wptr_r] <= fdata_i;
    end
  end

  // ==========================================================
  // output shifter on falling sck
  logic [2:0] obit_r;
  logic [7:0] osh_r;
  logic load;

  assign load = sck_fall && state_r == ST_OUT && obit_r == SFD_BIT_RST;
  assign pop = load && cnt_r != '0;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      obit_r <= SFD_BIT_RST;
      osh_r <= SFD_IDLE_OUT;
      so_o <= 1'b1;
      underrun_o <= 1'b0;
    end else begin
      underrun_o <= 1'b0;
      if (state_r != ST_OUT) begin
        obit_r <= SFD_BIT_RST;
      end else if (sck_fall) begin
        // one bit per clock once the header is in
        obit_r <= obit_r + 3'h1;
        if (load) begin
          // msb leaves first
          // missing data (fetch too slow) shows as ones
          osh_r <= pop ? {buf_r[rptr_r][6:0], 1'b1} : SFD_IDLE_OUT;
          so_o <= pop ? buf_r[rptr_r][7] : 1'b1;
          underrun_o <= !pop;
        end else begin
          so_o <= osh_r[7];
          osh_r <= {osh_r[6:0], 1'b1};
        end
      end
    end
  end

  // output released as soon as select rises
  assign so_oe_n_o = !(state_r == ST_OUT && !cs_s2_r);

endmodule : sfd_decoder
`default_nettype wire

// ### sfd_chk_sva.sv
// sfd_chk_sva: port-level timing checks for the serial flash command decoder
`timescale 1ns/10ps
`default_nettype none
module sfd_chk (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic so_o,
  input wire logic so_oe_n_o,
  input wire logic fetch_valid_o,
  input wire logic fetch_ready_i,
  input wire sfd_pkg::sfd_fetch_t fetch_o,
  input wire logic wbyte_valid_o,
  input wire logic done_valid_o,
  input wire logic abort_o
);
  import sfd_pkg::*;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  // ====================
  // sequences
  // select idle long enough to pass the two-stage sync
  sequence cs_idle;
    cs_n_i [*5];
  endsequence
  // a serial clock fall reached the sync chain a few cycles ago
  sequence sck_fell_recent;
    ($past(sck_i, 3) && !$past(sck_i, 2)) || ($past(sck_i, 4) && !$past(sck_i, 3))
      || ($past(sck_i, 5) && !$past(sck_i, 4));
  endsequence
  // ====================
  // link and report checks
  a_oe_released: assert property (cs_idle |-> so_oe_n_o)
    else $error("serial output driven while select idle");
  a_fetch_in_frame: assert property (fetch_valid_o |-> !$past(cs_n_i, 5))
    else $error("fetch request outside a frame");
  a_so_on_fall: assert property ($changed(so_o) && !so_oe_n_o && !$past(cs_n_i, 2)
    |-> sck_fell_recent)
    else $error("serial output moved without a clock fall");
  a_report_after_cs: assert property (done_valid_o || abort_o |-> cs_n_i && $past(cs_n_i, 3))
    else $error("report before select release");
  a_pulse_single: assert property (done_valid_o || abort_o |=> !done_valid_o && !abort_o)
    else $error("report pulse repeated");
  a_wbyte_gap: assert property (wbyte_valid_o |=> !wbyte_valid_o [*8])
    else $error("write bytes closer than one byte time");
  a_wbyte_frame: assert property (wbyte_valid_o |-> !$past(cs_n_i, 3))
    else $error("write byte outside a frame");
  a_fetch_hold: assert property (fetch_valid_o && !fetch_ready_i && !cs_n_i
    |=> fetch_valid_o && $stable(fetch_o))
    else $error("fetch request dropped or changed while waiting");
endmodule : sfd_chk
bind sfd_decoder sfd_chk u_chk (.mclk_i(mclk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i),
  .sck_i(sck_i), .so_o(so_o), .so_oe_n_o(so_oe_n_o), .fetch_valid_o(fetch_valid_o),
  .fetch_ready_i(fetch_ready_i), .fetch_o(fetch_o), .wbyte_valid_o(wbyte_valid_o),
  .done_valid_o(done_valid_o), .abort_o(abort_o));
`default_nettype wire

// ### sfd_spi_host.sv
// sfd_spi_host: behavioural spi master that frames bytes for the decoder
`timescale 1ns/10ps
`default_nettype none
module sfd_spi_host (
  input wire logic mclk_i,
  input wire logic so_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o
);
  // ====================
  // idle
  // mode 0, clock rests low
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end
  // ====================
  // frame, 160 ns clock (slow enough for either read opcode)
  // select, opcode then operands, msb first
  task automatic xfer(input logic [7:0] tx[$], input int nrx, input int tail,
      output logic [7:0] rx[$]);
    logic [7:0] b;
    int nb;
    rx = {};
    nb = (tx.size() + nrx) * 8 + tail;
    @(negedge mclk_i);
    cs_n_o = 1'b0;
    repeat (4) @(negedge mclk_i);
    for (int i = 0; i < nb; i++) begin
      si_o = i / 8 < tx.size() ? tx[i/8][7 - i%8] : ~si_o; // don't-care toggles
      repeat (4) @(negedge mclk_i);
      sck_o = 1'b1;
      repeat (4) @(negedge mclk_i);
      // sample late in high phase: device output lags the pin by its sync chain
      b = {b[6:0], so_i};
      sck_o = 1'b0;
      if (i % 8 == 7 && i / 8 >= tx.size()) rx.push_back(b);
    end
    repeat (4) @(negedge mclk_i);
    cs_n_o = 1'b1;
    si_o = ~si_o;
    repeat (12) @(negedge mclk_i);
  endtask : xfer
endmodule : sfd_spi_host
`default_nettype wire

// ### testbench.sv
// testbench: command frames, fetch source and report checks for the decoder
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sfd_pkg::*;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic cs_n, sck, si, so, so_oe_n, so_ln, f_val, d_rdy, w_val, dn_val, abt, unr;
  logic f_rdy = 1'b1;
  logic d_val = 1'b0;
  logic tk_f = 1'b0;
  logic tk_d = 1'b0;
  logic [7:0] d_byte = 8'h00;
  logic [7:0] wb, b;
  logic [23:0] a;
  sfd_fetch_t f_req, fq;
  sfd_done_t dn;
  int fails = 0;
  int cmp_count = 0;
  int n, seed;
  sfd_fetch_t pend[$];
  logic [37:0] exp_q[$];
  logic [7:0] wb_q[$], tx[$], rx[$];
  logic [7:0] ops[11] = '{8'h20, 8'h52, 8'hd8, 8'h36, 8'h39, 8'h60, 8'hc7, 8'h06, 8'h04,
    8'hb9, 8'hab};
  sfd_cmd_t cmds[11] = '{CMD_ERASE_4K, CMD_ERASE_32K, CMD_ERASE_64K, CMD_PROTECT,
    CMD_UNPROTECT, CMD_CHIP_ERASE, CMD_CHIP_ERASE, CMD_WR_EN, CMD_WR_DIS, CMD_PDOWN,
    CMD_RESUME};
  // ====================
  // clock, design, host
  always #10 mclk_i = ~mclk_i;
  // output pin pulled up while released
  assign so_ln = so_oe_n ? 1'b1 : so;
  sfd_decoder dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
    .so_o(so), .so_oe_n_o(so_oe_n), .fetch_valid_o(f_val), .fetch_ready_i(f_rdy),
    .fetch_o(f_req), .fdata_valid_i(d_val), .fdata_ready_o(d_rdy), .fdata_i(d_byte),
    .wbyte_valid_o(w_val), .wbyte_o(wb), .done_valid_o(dn_val), .done_o(dn), .abort_o(abt),
    .underrun_o(unr));
  sfd_spi_host u_host (.mclk_i(mclk_i), .so_i(so_ln), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
  // ====================
  // fetch source: in-order answers, stalls only while a byte is already owed
  function automatic logic [7:0] mem(input sfd_fetch_t f);
    return f.addr[7:0] ^ f.addr[21:14] ^ {6'h00, f.src};
  endfunction : mem
  // handshakes seen before the edge updates land
  always @(posedge mclk_i) begin
    tk_f = f_val && f_rdy;
    fq = f_req;
    tk_d = d_val && d_rdy;
  end
  always @(negedge mclk_i) begin
    if (tk_d) void'(pend.pop_front());
    if (tk_f) pend.push_back(fq);
    d_val = pend.size() != 0;
    d_byte = d_val ? mem(pend[0]) : ~d_byte;
    f_rdy = pend.size() == 0 || $urandom_range(1);
  end
  // ====================
  // compares and notes
  task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s: expected %h seen %h", nm, e, g);
    end
  endtask : cmp_byte
  // note: mode 0 full, 1 no count, 2 command only, 3 abort
  task automatic cmp_done(input logic [37:0] e, input logic ab);
    logic [35:0] k;
    k = e[37:36] == 2'h0 ? '1 : e[37:36] == 2'h1 ? 36'hffffffe00 : 36'hf80000000;
    if (e[37:36] == 2'h3) k = '0;
    cmp_count++;
    if (ab !== (e[37:36] == 2'h3) || ((dn ^ e[35:0]) & k) !== 36'h0) begin
      fails++;
      $display("wrong value done: expected %h seen %b %h", e, ab, dn);
    end
  endtask : cmp_done
  task automatic note(input logic [1:0] m, input sfd_cmd_t c, input logic [21:0] ad,
      input logic [8:0] cnt);
    exp_q.push_back({m, c, ad, cnt});
  endtask : note
  // report watcher, sampled mid-cycle
  always @(negedge mclk_i) begin
    if (dn_val || abt) cmp_done(exp_q.size() ? exp_q.pop_front() : 'x, abt);
    if (w_val) cmp_byte("write byte", wb_q.size() ? wb_q.pop_front() : 8'hxx, wb);
    if (unr) cmp_byte("underrun", 8'h00, 8'h01);
  end
  // ====================
  // read frame: header, n bytes, then a partial byte before release
  task automatic rd(input logic [7:0] op, input sfd_src_t s, input sfd_cmd_t c, input int na,
      input logic [23:0] ad, input int dm, input int cnt);
    sfd_fetch_t f;
    tx = {op};
    for (int i = na - 1; i >= 0; i--) tx.push_back(ad[i*8 +: 8]);
    if (dm != 0) tx.push_back(8'($urandom));
    note(na != 0 ? 2'h1 : 2'h2, c, ad[21:0], 9'h0);
    u_host.xfer(tx, cnt, 3, rx);
    f.src = s;
    for (int i = 0; i < cnt; i++) begin
      f.addr = ad[21:0] + 22'(i);
      cmp_byte("read byte", mem(f), rx[i]);
    end
  endtask : rd
  task automatic wrap_up;
    if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // watchdog, about seven times the expected run
  initial begin
    #1000000;
    fails++;
    wrap_up();
  end
  // ====================
  // main sequence
  initial begin
    seed = $urandom(32'hb48845cc);
    repeat (4) @(negedge mclk_i);
    rstn_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    // unknown opcodes with a program opcode buried inside
    tx = {8'hff, 8'h02, 8'h00, 8'h00, 8'h00, 8'h11};
    u_host.xfer(tx, 0, 0, rx);
    tx[0] = 8'h00;
    u_host.xfer(tx, 0, 0, rx);
    // every read source, wrap at array end
    rd(8'h03, SRC_ARRAY, CMD_READ_SLOW, 3, 24'hfffffe, 0, 4);
    rd(8'h0b, SRC_ARRAY, CMD_READ_FAST, 3, 24'($urandom), 1, 3);
    rd(8'h3c, SRC_PROT, CMD_READ_PROT, 3, 24'($urandom), 0, 2);
    rd(8'h05, SRC_STATUS, CMD_READ_STAT, 0, 24'h0, 0, 2);
    rd(8'h9f, SRC_ID, CMD_READ_ID, 0, 24'h0, 0, 4);
    // program bytes pass through and are counted
    n = 1 + $urandom_range(3);
    a = 24'($urandom);
    tx = {8'h02, a[23:16], a[15:8], a[7:0]};
    repeat (n) begin
      b = 8'($urandom);
      tx.push_back(b);
      wb_q.push_back(b);
    end
    note(2'h0, CMD_PROGRAM, a[21:0], 9'(n));
    u_host.xfer(tx, 0, 0, rx);
    // status write keeps its first byte only
    tx = {8'h01, 8'($urandom), 8'h5a};
    wb_q.push_back(tx[1]);
    note(2'h2, CMD_WRITE_STAT, 22'h0, 9'h1);
    u_host.xfer(tx, 0, 0, rx);
    // address-only and operand-free commands, extra byte ignored
    foreach (ops[i]) begin
      a = 24'($urandom);
      tx = {ops[i]};
      if (i < 5) tx = {tx, a[23:16], a[15:8], a[7:0]};
      tx.push_back(8'($urandom));
      note(i < 5 ? 2'h1 : 2'h2, cmds[i], a[21:0], 9'h0);
      u_host.xfer(tx, 0, 0, rx);
    end
    // early release: short address, program without data, short opcode
    repeat (3) note(2'h3, CMD_NONE, 22'h0, 9'h0);
    tx = {8'h03, 8'h12, 8'h34};
    u_host.xfer(tx, 0, 0, rx);
    tx = {8'h02, 8'h00, 8'h01, 8'h02};
    u_host.xfer(tx, 0, 0, rx);
    tx = {};
    u_host.xfer(tx, 0, 5, rx);
    repeat (20) @(negedge mclk_i);
    cmp_byte("notes left", 8'h00, 8'(exp_q.size() + wb_q.size()));
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
